// file: shared/trace_gate_defines.svh
// register offsets, field positions and reset values of the trace access gate
// assumes a 32-bit apb slave with word-aligned registers
`ifndef TRACE_GATE_DEFINES_SVH
`define TRACE_GATE_DEFINES_SVH

// ==========================================================
// register byte offsets
`define TG_OFS_CTRL            12'h000
`define TG_OFS_STATUS          12'h004
`define TG_OFS_ERRCNT          12'h008
`define TG_OFS_TRACE_STATUS    12'h00C
`define TG_ADDR_W              12

// ==========================================================
// control register fields
`define TG_CTRL_SPLIT          0
`define TG_CTRL_PD             1
`define TG_CTRL_SR_LOCK        2
`define TG_CTRL_WR_LOCK        3
`define TG_CTRL_W              4
`define TG_CTRL_RST            4'h0

// ==========================================================
// status register fields
`define TG_ST_INPUTS_LSB       0
`define TG_ST_INPUTS_W         6
`define TG_ST_STATE_LSB        8
`define TG_ST_CODE_LSB         12
`define TG_TS_SR_READY         1

// ==========================================================
// counter width
`define TG_ERRCNT_W            16
`define TG_ERRCNT_RST          16'h0000

`endif

// file: shared/trace_gate_pkg.sv
// types shared by the trace access gate and its bench
// assumes trace_gate_defines.svh is included where offsets are needed
`default_nettype none

package trace_gate_pkg;

  // ==========================================================
  // requesting path
  typedef enum logic [1:0] {
    path_debugger,
    path_memmap,
    path_coproc
  } path_t;

  // ==========================================================
  // register groups
  typedef enum logic [3:0] {
    grp_trace,
    grp_lock_status,
    grp_lock_access,
    grp_powerdown_status,
    grp_sr_lock_status,
    grp_sr_lock_access,
    grp_save_restore,
    grp_devid_auth,
    grp_itctrl,
    grp_other_mgmt,
    grp_res_trace,
    grp_res_mgmt
  } group_t;

  // ==========================================================
  // access outcome
  typedef enum logic [2:0] {
    out_ok,
    out_error,
    out_not_possible,
    out_write_ignored,
    out_unpredictable,
    out_unknown_sbzp
  } outcome_t;

  // ==========================================================
  // classified state
  typedef enum logic [2:0] {
    st_default,
    st_no_power,
    st_no_core,
    st_non_priv,
    st_sr_lock
  } state_t;

endpackage : trace_gate_pkg

`default_nettype wire

// file: src/trace_reg_access_gate.sv
// access gate deciding the outcome of every trace register access
// assumes requests come from logic on sys_clk; power and privilege levels are pins
// Functional notes
// - single power: off, or debug disabled on the memory-mapped path, is unpowered
// - single power: coprocessor non-privileged needs power, user, disable
// - no special state: per-group default outcome
// - unpowered debugger accesses always error
// - unpowered memory-mapped accesses always error
// - write lock ignores memory-mapped writes to trace, save-restore lock access, itctrl and other management groups
// - power-down bit ignores trace writes except control, outside save-restore lock state
// - coprocessor: unpowered impossible in single power, core off impossible in split, non-privileged error
// - split: debug off blocks debugger and memory-mapped, debug disabled blocks memory-mapped
// - split: core off is no-core; debug-off outranks it
// - save-restore lock needs both powered, flag set
// - split non-privileged needs power, outranks lock
// - no debug power: debugger accesses error
`default_nettype none
`include "trace_gate_defines.svh"

module trace_reg_access_gate (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // power and privilege pins
  input  wire logic                        trace_pwr_up,
  input  wire logic                        core_pwr_up,
  input  wire logic                        software_debug_enable,
  input  wire logic                        cpu_non_priv,
  input  wire logic                        coprocessor_access_ctrl_dis,
  input  wire logic                        nonsecure_access_ctrl_dis,
  input  wire logic                        hyp_coprocessor_trap_dis,
  // access request
  input  wire logic                        req_valid,
  input  wire logic [1:0]                  req_path,
  input  wire logic [3:0]                  req_group,
  input  wire logic                        req_write,
  input  wire logic                        req_main_ctrl,
  // access answer
  output logic                             resp_valid,
  output logic      [2:0]                  resp_outcome,
  output logic      [2:0]                  resp_state,
  output logic                             resp_commit,
  output logic                             resp_ctrl_bits_only
);

  // ==========================================================
  // pin synchronisers
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_q;

  assign pin_raw = {hyp_coprocessor_trap_dis, nonsecure_access_ctrl_dis, coprocessor_access_ctrl_dis,
                    cpu_non_priv, software_debug_enable, core_pwr_up, trace_pwr_up};

  // cleared in reset, so the gate starts out classifying every access as unpowered
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pin_meta_q[gi] <= 1'b0;
          pin_q[gi]      <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_q[gi]      <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  logic pwr_s, core_s, swen_s, nonpriv_s, cp_dis_s;
  assign pwr_s     = pin_q[0];
  assign core_s    = pin_q[1];
  assign swen_s    = pin_q[2];
  assign nonpriv_s = pin_q[3];
  assign cp_dis_s  = |pin_q[6:4];

  // ==========================================================
  // control register state
  logic [`TG_CTRL_W-1:0]   ctrl_q;
  logic [`TG_ERRCNT_W-1:0] errcnt_q;
  logic                    split_mode, power_down_ctrl_bit, save_restore_lock, mm_write_lock;

  assign split_mode          = ctrl_q[`TG_CTRL_SPLIT];
  assign power_down_ctrl_bit = ctrl_q[`TG_CTRL_PD];
  assign save_restore_lock   = ctrl_q[`TG_CTRL_SR_LOCK];
  assign mm_write_lock       = ctrl_q[`TG_CTRL_WR_LOCK];

  // ==========================================================
  // state classification
  trace_gate_pkg::path_t  path;
  trace_gate_pkg::group_t grp;
  trace_gate_pkg::state_t state_d;
  logic                   is_cp, is_mm, no_dbg_pwr, non_priv_cond;

  // path code 3 is not defined and falls through as a debugger access
  assign path  = trace_gate_pkg::path_t'(req_path);
  assign grp   = trace_gate_pkg::group_t'(req_group);
  assign is_cp = (path == trace_gate_pkg::path_coproc);
  assign is_mm = (path == trace_gate_pkg::path_memmap);

  // memory-mapped path is also shut out by debug disable
  assign no_dbg_pwr    = !pwr_s || (is_mm && !swen_s);
  assign non_priv_cond = is_cp && nonpriv_s && cp_dis_s;

  always_comb begin
    state_d = trace_gate_pkg::st_default;
    if (!split_mode) begin
      if (no_dbg_pwr)
        state_d = trace_gate_pkg::st_no_power;
      else if (non_priv_cond)
        state_d = trace_gate_pkg::st_non_priv;
    end else begin
      // coprocessor path ignores debug power: its default column covers that case
      if (!is_cp && no_dbg_pwr)
        state_d = trace_gate_pkg::st_no_power;
      else if (!core_s)
        state_d = trace_gate_pkg::st_no_core;
      else if (non_priv_cond && pwr_s)
        state_d = trace_gate_pkg::st_non_priv;
      else if (pwr_s && core_s && save_restore_lock)
        state_d = trace_gate_pkg::st_sr_lock;
    end
  end

  // ==========================================================
  // outcome tables
  trace_gate_pkg::outcome_t outcome_d;
  logic                     commit_d, ctrl_only_d, pd_blocks;

  // save-restore lock state keeps trace registers writable whatever the power-down bit says
  assign pd_blocks = power_down_ctrl_bit && (state_d != trace_gate_pkg::st_sr_lock);

  always_comb begin
    outcome_d = trace_gate_pkg::out_ok;
    case (state_d)
      trace_gate_pkg::st_no_power: begin
        // coprocessor requests cannot reach an unpowered unit at all
        if (is_cp)
          outcome_d = trace_gate_pkg::out_not_possible;
        else
          outcome_d = trace_gate_pkg::out_error;
      end
      trace_gate_pkg::st_no_core: begin
        if (is_cp)
          outcome_d = trace_gate_pkg::out_not_possible;
        else if (grp == trace_gate_pkg::grp_trace)
          outcome_d = trace_gate_pkg::out_error;
        else if (grp == trace_gate_pkg::grp_res_trace || grp == trace_gate_pkg::grp_res_mgmt)
          outcome_d = trace_gate_pkg::out_unknown_sbzp;
      end
      trace_gate_pkg::st_non_priv: begin
        outcome_d = trace_gate_pkg::out_error;
      end
      default: begin
        case (path)
          trace_gate_pkg::path_coproc: begin
            case (grp)
              trace_gate_pkg::grp_trace,
              trace_gate_pkg::grp_sr_lock_status,
              trace_gate_pkg::grp_sr_lock_access,
              trace_gate_pkg::grp_devid_auth:       outcome_d = trace_gate_pkg::out_ok;
              trace_gate_pkg::grp_res_trace:        outcome_d = trace_gate_pkg::out_unknown_sbzp;
              default:                              outcome_d = trace_gate_pkg::out_unpredictable;
            endcase
          end
          trace_gate_pkg::path_memmap: begin
            case (grp)
              trace_gate_pkg::grp_save_restore:     outcome_d = trace_gate_pkg::out_unpredictable;
              trace_gate_pkg::grp_res_trace,
              trace_gate_pkg::grp_res_mgmt:         outcome_d = trace_gate_pkg::out_unknown_sbzp;
              trace_gate_pkg::grp_trace,
              trace_gate_pkg::grp_sr_lock_access,
              trace_gate_pkg::grp_itctrl,
              trace_gate_pkg::grp_other_mgmt: begin
                if (mm_write_lock && req_write)
                  outcome_d = trace_gate_pkg::out_write_ignored;
              end
              default:                              outcome_d = trace_gate_pkg::out_ok;
            endcase
          end
          default: begin
            case (grp)
              trace_gate_pkg::grp_lock_access:      outcome_d = trace_gate_pkg::out_unpredictable;
              trace_gate_pkg::grp_save_restore:     outcome_d = trace_gate_pkg::out_unpredictable;
              trace_gate_pkg::grp_res_trace,
              trace_gate_pkg::grp_res_mgmt:         outcome_d = trace_gate_pkg::out_unknown_sbzp;
              default:                              outcome_d = trace_gate_pkg::out_ok;
            endcase
          end
        endcase
        if (outcome_d == trace_gate_pkg::out_ok && req_write && grp == trace_gate_pkg::grp_trace
            && pd_blocks && !req_main_ctrl)
          outcome_d = trace_gate_pkg::out_write_ignored;
      end
    endcase
  end

  // only an ok write changes contents; error, impossible and ignored never do
  assign commit_d    = req_write && (outcome_d == trace_gate_pkg::out_ok);
  assign ctrl_only_d = commit_d && grp == trace_gate_pkg::grp_trace && pd_blocks && req_main_ctrl;

  // ==========================================================
  // answer register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      resp_valid          <= 1'b0;
      resp_outcome        <= 3'h0;
      resp_state          <= 3'h0;
      resp_commit         <= 1'b0;
      resp_ctrl_bits_only <= 1'b0;
    end else begin
      // outcome fields hold between answers so the status register shows the last one
      resp_valid <= req_valid;
      if (req_valid) begin
        resp_outcome        <= outcome_d;
        resp_state          <= state_d;
        resp_commit         <= commit_d;
        resp_ctrl_bits_only <= ctrl_only_d;
      end
    end
  end

  // ==========================================================
  // error counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      errcnt_q <= `TG_ERRCNT_RST;
    // saturates rather than wraps, so a flood of refusals never reads as none
    else if (req_valid && outcome_d == trace_gate_pkg::out_error && ~&errcnt_q)
      errcnt_q <= errcnt_q + `TG_ERRCNT_W'(1);
  end

  // ==========================================================
  // apb slave, one wait state
  logic                 acc;
  logic                 mapped;
  logic [`TG_ADDR_W-1:0] ofs;
  logic [31:0]          rd_d;

  assign acc = psel && penable && !pready;
  assign ofs = paddr[`TG_ADDR_W-1:0];

  always_comb begin
    rd_d   = 32'h0000_0000;
    mapped = (paddr[31:`TG_ADDR_W] == '0) && (paddr[1:0] == 2'h0);
    case (ofs)
      `TG_OFS_CTRL:   rd_d[`TG_CTRL_W-1:0] = ctrl_q;
      `TG_OFS_STATUS: begin
        rd_d[`TG_ST_INPUTS_LSB +: `TG_ST_INPUTS_W] = {cp_dis_s, nonpriv_s, swen_s, core_s, pwr_s, resp_commit};
        rd_d[`TG_ST_STATE_LSB +: 3]                = resp_state;
        rd_d[`TG_ST_CODE_LSB +: 3]                 = resp_outcome;
      end
      `TG_OFS_ERRCNT: rd_d[`TG_ERRCNT_W-1:0] = errcnt_q;
      // ready to save once both domains are up and the lock holds the unit still
      `TG_OFS_TRACE_STATUS: rd_d[`TG_TS_SR_READY] = save_restore_lock && pwr_s && core_s;
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      // zero outside the ready cycle so a stale word never leaks to another master
      prdata  <= (acc && !pwrite && mapped) ? rd_d : 32'h0000_0000;
    end
  end

  // write lands on the completing edge only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      ctrl_q <= `TG_CTRL_RST;
    else if (psel && penable && pready && pwrite && mapped && ofs == `TG_OFS_CTRL)
      ctrl_q <= pwdata[`TG_CTRL_W-1:0];
  end

endmodule : trace_reg_access_gate

`default_nettype wire

// file: verif/trace_access_requester.sv
// behavioural requester standing for the debugger, bus and coprocessor paths
// assumes one request at a time, launched just after a rising edge of sys_clk
`default_nettype none

module trace_access_requester (
  // clock
  input  wire logic       sys_clk,
  // request
  output logic            req_valid,
  output logic [1:0]      req_path,
  output logic [3:0]      req_group,
  output logic            req_write,
  output logic            req_main_ctrl,
  // answer
  input  wire logic       resp_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_valid     = 1'b0;
    req_path      = 2'h0;
    req_group     = 4'h0;
    req_write     = 1'b0;
    req_main_ctrl = 1'b0;
  end

  // =======
  // one-cycle pulse; fields turned round afterwards so stale values never look valid
  task automatic access(input logic [1:0] pth, input logic [3:0] grp, input logic [1:0] wm, output logic seen);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid     <= 1'b1;
    req_path      <= pth;
    req_group     <= grp;
    {req_write, req_main_ctrl} <= wm;
    @(posedge sys_clk);
    req_valid     <= 1'b0;
    req_path      <= ~pth;
    req_group     <= ~grp;
    {req_write, req_main_ctrl} <= ~wm;
    do begin
      @(negedge sys_clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 4);
    // only the answer flag is used, never the outcome or state of the access
    seen = resp_valid;
  endtask : access
endmodule : trace_access_requester

`default_nettype wire

// file: verif/trace_reg_access_gate_asserts.sv
// checker of the trace register access gate, bound to its ports
// assumes codes in trace_gate_pkg order; pins reach the gate through two flops
`default_nettype none

module trace_reg_access_gate_asserts (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins
  input wire logic       trace_pwr_up,
  input wire logic       core_pwr_up,
  input wire logic       software_debug_enable,
  input wire logic       cpu_non_priv,
  input wire logic       coprocessor_access_ctrl_dis,
  input wire logic       nonsecure_access_ctrl_dis,
  input wire logic       hyp_coprocessor_trap_dis,
  // request and answer
  input wire logic       req_valid,
  input wire logic [1:0] req_path,
  input wire logic       resp_valid,
  input wire logic [2:0] resp_outcome,
  input wire logic [2:0] resp_state,
  input wire logic       resp_commit,
  input wire logic       resp_ctrl_bits_only
);
  // =======
  // pin history: only judge requests whose pins have settled past the flops
  logic [6:0]  pins;
  logic [20:0] hist_q;
  logic        steady;
  logic        any_dis;
  assign pins    = {trace_pwr_up, core_pwr_up, software_debug_enable, cpu_non_priv,
                    coprocessor_access_ctrl_dis, nonsecure_access_ctrl_dis, hyp_coprocessor_trap_dis};
  assign steady  = (hist_q == {3{pins}});
  assign any_dis = coprocessor_access_ctrl_dis | nonsecure_access_ctrl_dis | hyp_coprocessor_trap_dis;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hist_q <= 21'h00000;
    end else begin
      hist_q <= {hist_q[13:0], pins};
    end
  end

  // =======
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  resp_follow_a: assert property (req_valid |=> resp_valid)
    else $error("answer missing after request");
  resp_only_a: assert property (!req_valid |=> !resp_valid)
    else $error("answer without request");
  resp_hold_a: assert property (!req_valid |=> $stable(resp_outcome) && $stable(resp_state))
    else $error("answer changed without request");
  unpowered_err_a: assert property (req_valid && steady && !trace_pwr_up && req_path != 2'h2
    |=> resp_outcome == 3'h1 && resp_state == 3'h1) else $error("unpowered access not error");
  swen_err_a: assert property (req_valid && steady && !software_debug_enable && req_path == 2'h1
    |=> resp_outcome == 3'h1 && resp_state == 3'h1) else $error("bus access with debug disabled not error");
  non_priv_a: assert property (req_valid && steady && req_path == 2'h2 && cpu_non_priv && any_dis
    && trace_pwr_up && core_pwr_up |=> resp_outcome == 3'h1 && resp_state == 3'h3) else $error("non-priv not error");
  commit_ok_a: assert property (resp_valid && resp_commit |-> resp_outcome == 3'h0)
    else $error("write committed on a refused access");
  bits_only_a: assert property (resp_ctrl_bits_only |-> resp_commit)
    else $error("control bits flagged without commit");
  apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not one pulse");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("slave error outside ready");
  cp_no_power_a: assert property (req_valid && req_path == 2'h2 |=> resp_state != 3'h1 || resp_outcome == 3'h2)
    else $error("unpowered coprocessor access not refused as impossible");

  cover property (resp_valid && resp_state == 3'h4);
  cover property (resp_valid && resp_ctrl_bits_only);
  cover property (pready && pslverr);
endmodule : trace_reg_access_gate_asserts

bind trace_reg_access_gate trace_reg_access_gate_asserts u_chk (
  .sys_clk, .rstn, .psel, .penable, .pready, .pslverr, .trace_pwr_up, .core_pwr_up, .software_debug_enable,
  .cpu_non_priv, .coprocessor_access_ctrl_dis, .nonsecure_access_ctrl_dis, .hyp_coprocessor_trap_dis,
  .req_valid, .req_path, .resp_valid, .resp_outcome, .resp_state, .resp_commit, .resp_ctrl_bits_only
);

`default_nettype wire

// file: verif/trace_reg_access_gate_test.sv
// self-checking bench of the trace register access gate
// assumes the requester model and the bound checker; codes follow trace_gate_pkg order
`default_nettype none
`include "trace_gate_defines.svh"
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end

module trace_reg_access_gate_test;
  timeunit 1ns;
  timeprecision 1ns;
  // =======
  // signals
  logic        sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, err, req_valid, req_write, req_main_ctrl, resp_valid, resp_commit;
  logic        resp_ctrl_bits_only;
  logic [1:0]  req_path;
  logic [3:0]  req_group;
  logic [2:0]  resp_outcome, resp_state;
  logic [6:0]  pins = 7'h00; // power, core, sw enable, non-priv, three disables
  int          n_mismatch = 0, checks_done = 0, n_err = 0;

  always #25 sys_clk = ~sys_clk;

  trace_reg_access_gate u_dut (
    .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .trace_pwr_up(pins[6]), .core_pwr_up(pins[5]), .software_debug_enable(pins[4]), .cpu_non_priv(pins[3]),
    .coprocessor_access_ctrl_dis(pins[2]), .nonsecure_access_ctrl_dis(pins[1]), .hyp_coprocessor_trap_dis(pins[0]),
    .req_valid, .req_path, .req_group, .req_write, .req_main_ctrl,
    .resp_valid, .resp_outcome, .resp_state, .resp_commit, .resp_ctrl_bits_only
  );
  trace_access_requester u_req (.sys_clk, .req_valid, .req_path, .req_group, .req_write, .req_main_ctrl, .resp_valid);

  // =======
  // tasks
  task automatic apb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {20'h00000, ofs};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait-state count assumed; a stuck slave is left to the watchdog
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
  endtask : apb

  // control word, pins, path, group, {write, main control}, outcome, state
  task automatic run(input logic [3:0] ctl, input logic [6:0] pn, input logic [1:0] pth, input logic [3:0] grp,
                     input logic [1:0] wm, input logic [2:0] eo, input logic [2:0] es);
    logic seen;
    logic ok_wr;
    apb(1'b1, `TG_OFS_CTRL, {28'h0000000, ctl});
    pins <= pn;
    // pins cross two flops before the gate sees them
    repeat (3) @(posedge sys_clk);
    u_req.access(pth, grp, wm, seen);
    ok_wr = wm[1] && eo == 3'h0;
    if (eo == 3'h1) n_err++;
    `CHK("answer", seen, 1'b1)
    `CHK("outcome", resp_outcome, eo)
    `CHK("state", resp_state, es)
    `CHK("commit", resp_commit, ok_wr)
    `CHK("ctrl bits", resp_ctrl_bits_only, ok_wr && wm[0] && ctl[1] && es != 3'h4 && grp == 4'h0)
  endtask : run

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, `TG_OFS_CTRL, 32'h00000000);
    `CHK("ctrl reset", rd, 32'h00000000)
    apb(1'b1, `TG_OFS_CTRL, 32'hFFFFFFFF);
    apb(1'b0, `TG_OFS_CTRL, 32'h00000000);
    `CHK("ctrl width", rd, 32'h0000000F)
    apb(1'b0, 12'h010, 32'h00000000);
    `CHK("unmapped", {err, rd}, {1'b1, 32'h00000000})
    apb(1'b1, 12'h002, 32'h00000000);
    `CHK("misaligned", err, 1'b1)
    apb(1'b0, `TG_OFS_CTRL, 32'h00000000);
    `CHK("refused write", rd, 32'h0000000F)
    // single power
    run(4'h0, 7'h30, 2'h0, 4'h0, 2'h0, 3'h1, 3'h1);
    run(4'h0, 7'h30, 2'h3, 4'hB, 2'h2, 3'h1, 3'h1);
    run(4'h0, 7'h60, 2'h1, 4'h1, 2'h0, 3'h1, 3'h1);
    run(4'h0, 7'h30, 2'h1, 4'h7, 2'h0, 3'h1, 3'h1);
    run(4'h0, 7'h30, 2'h2, 4'h0, 2'h0, 3'h2, 3'h1);
    run(4'h0, 7'h7C, 2'h2, 4'h0, 2'h2, 3'h1, 3'h3);
    run(4'h0, 7'h7A, 2'h2, 4'h5, 2'h0, 3'h1, 3'h3);
    run(4'h0, 7'h79, 2'h2, 4'h7, 2'h0, 3'h1, 3'h3);
    run(4'h0, 7'h74, 2'h2, 4'h0, 2'h2, 3'h0, 3'h0);
    run(4'h0, 7'h78, 2'h2, 4'h1, 2'h0, 3'h4, 3'h0);
    run(4'h0, 7'h70, 2'h2, 4'h9, 2'h2, 3'h4, 3'h0);
    run(4'h0, 7'h70, 2'h2, 4'h5, 2'h2, 3'h0, 3'h0);
    run(4'h0, 7'h70, 2'h2, 4'hB, 2'h0, 3'h4, 3'h0);
    run(4'h0, 7'h70, 2'h2, 4'hA, 2'h0, 3'h5, 3'h0);
    run(4'h0, 7'h70, 2'h1, 4'hA, 2'h0, 3'h5, 3'h0);
    run(4'h0, 7'h50, 2'h1, 4'h6, 2'h0, 3'h4, 3'h0);
    run(4'h0, 7'h70, 2'h0, 4'h2, 2'h2, 3'h4, 3'h0);
    run(4'h8, 7'h70, 2'h1, 4'h8, 2'h2, 3'h3, 3'h0);
    run(4'h8, 7'h70, 2'h1, 4'h5, 2'h2, 3'h3, 3'h0);
    run(4'h2, 7'h70, 2'h0, 4'h0, 2'h2, 3'h3, 3'h0);
    run(4'h2, 7'h70, 2'h0, 4'h0, 2'h3, 3'h0, 3'h0);
    // split power
    run(4'h1, 7'h30, 2'h0, 4'h4, 2'h0, 3'h1, 3'h1);
    run(4'h1, 7'h60, 2'h1, 4'h0, 2'h0, 3'h1, 3'h1);
    run(4'h1, 7'h10, 2'h0, 4'h0, 2'h0, 3'h1, 3'h1);
    run(4'h1, 7'h50, 2'h0, 4'h0, 2'h0, 3'h1, 3'h2);
    run(4'h1, 7'h10, 2'h2, 4'h0, 2'h0, 3'h2, 3'h2);
    run(4'h5, 7'h70, 2'h0, 4'h0, 2'h2, 3'h0, 3'h4);
    apb(1'b0, `TG_OFS_TRACE_STATUS, 32'h00000000);
    `CHK("save ready", rd, 32'h00000002)
    run(4'h5, 7'h50, 2'h1, 4'h0, 2'h0, 3'h1, 3'h2);
    run(4'h5, 7'h7C, 2'h2, 4'h0, 2'h0, 3'h1, 3'h3);
    run(4'h7, 7'h70, 2'h1, 4'h0, 2'h2, 3'h0, 3'h4);
    apb(1'b0, `TG_OFS_STATUS, 32'h00000000);
    `CHK("status", rd, 32'h0000040F)
    apb(1'b0, `TG_OFS_ERRCNT, 32'h00000000);
    `CHK("error count", rd, n_err[31:0])
    test_done;
  end
endmodule : trace_reg_access_gate_test

`default_nettype wire
